// ### dv/reset_source_controller_tb.sv
// Purpose: self-checking bench for the reset source controller.
// Assumes: short delay parameters so every release takes tens of cycles.
// Notes:   sources are hit one at a time, cause flags read over APB.
`timescale 1ns/1ps
`include "reset_source_controller_map.svh"

module reset_source_controller_tb;
	localparam int US[4] = '{1, 2, 3, 4}; // shortened delay per select

	logic        clk;                    // 10 MHz system clock
	logic        reset_n;                // from the supply model
	logic        ext_reset_pin_n;        // from the supply model
	logic        brownout_low;           // from the supply model
	logic        watchdog_timeout;       // one-cycle pulse
	logic [1:0]  startup_time_select;    // delay select fuse
	logic        external_reset_disable; // pin disable fuse
	logic        psel;                   // apb select
	logic        penable;                // apb access phase
	logic        pwrite;                 // apb direction
	logic [11:0] paddr;                  // apb address
	logic [31:0] pwdata;                 // apb write data
	logic [31:0] prdata;                 // apb read data
	logic        pready;                 // apb answer
	logic        pslverr;                // apb error
	logic        sys_reset_n;            // stretched reset
	logic        ports_reset_n;          // port reset
	logic        irq;                    // cause interrupt
	logic [31:0] rd;                     // last read data
	logic        slv;                    // last error flag
	int          fail_count;             // mismatches
	int          checks_done;            // comparisons

	always #50 clk = ~clk;

	reset_source_controller #(
		.DELAY_US_0(US[0]),
		.DELAY_US_1(US[1]),
		.DELAY_US_2(US[2]),
		.DELAY_US_3(US[3])
	) uut (
		.clk(clk), .reset_n(reset_n), .ext_reset_pin_n(ext_reset_pin_n),
		.brownout_low(brownout_low), .watchdog_timeout(watchdog_timeout),
		.startup_time_select(startup_time_select),
		.external_reset_disable(external_reset_disable),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sys_reset_n(sys_reset_n),
		.ports_reset_n(ports_reset_n), .irq(irq)
	);

	supply_reset_model supply (
		.clk(clk), .reset_n(reset_n), .ext_reset_pin_n(ext_reset_pin_n),
		.brownout_low(brownout_low)
	);

	// ------------------------------------------------------------
	// checking and closing
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_verdict;
		$display("counts: %0d checks, %0d mismatches", checks_done,
			fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// apb master: setup, then access held until pready
	// ------------------------------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a,
			input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		// values read here are those sampled at the edge
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			chk("pready", 32'h1, 32'h0);
			give_verdict();
		end
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp,
			input string what);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
		chk({what, " error"}, 32'h0, {31'h0, slv});
	endtask

	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	// ------------------------------------------------------------
	// reset sources: 0 supply, 1 pin, 2 brown-out, 3 watchdog
	// ------------------------------------------------------------
	task automatic set_source(input int which, input logic on);
		case (which)
		0: supply.drive_supply(!on);
		1: supply.drive_pin(!on);
		2: supply.drive_brownout(on);
		default: watchdog_timeout <= on;
		endcase
	endtask

	// counts edges to release; window allows for sync and hold cycles
	task automatic wait_release(input string what);
		int c;
		int n;
		n = US[startup_time_select] * `RSC_CLK_MHZ;
		c = 0;
		while (sys_reset_n !== 1'b1 && c < n + 40) begin
			@(posedge clk);
			c++;
		end
		checks_done++;
		if (c < n - 2 || c > n + 6) begin
			fail_count++;
			$display("CHECK FAILED %s release expected %0d seen %0d",
				what, n, c);
		end
		if (c >= n + 40) give_verdict();
	endtask

	task automatic hit_source(input int which, input logic hits,
			input string what);
		@(posedge clk);
		set_source(which, 1'b1);
		#1;
		if (which < 3) begin
			chk({what, " port"}, {31'h0, !hits},
				{31'h0, ports_reset_n});
		end
		if (which == 0) begin
			chk({what, " at once"}, 32'h0, {31'h0, sys_reset_n});
		end
		@(posedge clk);
		// watchdog pulse is exactly one cycle wide
		if (which == 3) set_source(3, 1'b0);
		repeat ((which == 3) ? 1 : (which == 0) ? 10 : 5) @(posedge clk);
		chk({what, " held"}, {31'h0, !hits}, {31'h0, sys_reset_n});
		set_source(which, 1'b0);
		if (hits) wait_release(what);
		else repeat (4) @(posedge clk);
		$display("test %s done", what);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		watchdog_timeout = 1'b0;
		startup_time_select = 2'h0;
		external_reset_disable = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		fail_count = 0;
		checks_done = 0;
		// every delay select code, from power-on
		for (int s = 0; s < 4; s++) begin
			startup_time_select <= s[1:0];
			hit_source(0, 1'b1, "power-on");
		end
		rchk(`RSC_OFF_CAUSE, 32'h1, "cause after power-on");
		rchk(`RSC_OFF_CONFIG, 32'h2, "config reset");
		rchk(`RSC_OFF_IRQ_STAT, 32'h1, "irq status");
		rchk(`RSC_OFF_IRQ_EN, 32'h0, "irq enable reset");
		// interrupt raised, masked, cleared
		apb(1'b1, `RSC_OFF_IRQ_EN, 32'h1);
		settle();
		chk("irq raised", 32'h1, {31'h0, irq});
		apb(1'b1, `RSC_OFF_IRQ_EN, 32'h0);
		settle();
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, `RSC_OFF_IRQ_EN, 32'h1);
		apb(1'b1, `RSC_OFF_IRQ_CLR, 32'h1);
		settle();
		chk("irq cleared", 32'h0, {31'h0, irq});
		rchk(`RSC_OFF_IRQ_STAT, 32'h0, "irq status cleared");
		// one keeps the power-on flag, pin adds its own
		apb(1'b1, `RSC_OFF_CAUSE, 32'hFFFF_FFF1);
		hit_source(1, 1'b1, "pin");
		rchk(`RSC_OFF_CAUSE, 32'h3, "cause after pin");
		apb(1'b1, `RSC_OFF_CAUSE, 32'h2);
		rchk(`RSC_OFF_CAUSE, 32'h2, "power-on flag cleared");
		hit_source(2, 1'b1, "brown-out");
		rchk(`RSC_OFF_CAUSE, 32'h6, "cause after brown-out");
		// pin ignored by config bit and by fuse
		apb(1'b1, `RSC_OFF_CONFIG, 32'h6);
		hit_source(1, 1'b0, "pin off by config");
		apb(1'b1, `RSC_OFF_CONFIG, 32'h2);
		external_reset_disable <= 1'b1;
		hit_source(1, 1'b0, "pin off by fuse");
		external_reset_disable <= 1'b0;
		apb(1'b1, `RSC_OFF_CONFIG, 32'h0);
		hit_source(2, 1'b0, "brown-out off");
		hit_source(3, 1'b0, "watchdog off");
		apb(1'b1, `RSC_OFF_CONFIG, 32'h1);
		hit_source(3, 1'b1, "watchdog");
		rchk(`RSC_OFF_CAUSE, 32'hE, "cause after watchdog");
		// unmapped place answers with an error and zero data
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, slv});
		chk("unmapped data", 32'h0, rd);
		hit_source(0, 1'b1, "power-on again");
		rchk(`RSC_OFF_CAUSE, 32'h1, "cause, power-on 2");
		rchk(`RSC_OFF_CONFIG, 32'h2, "config after power-on");
		give_verdict();
	end
endmodule // reset_source_controller_tb

// ### dv/supply_reset_model.sv
// Purpose: stand-in for the reset pin driver and the supply detectors.
// Assumes: levels change by non-blocking assignment after a clock edge.
// Notes:   every line is driven at all times; none is left floating.
`timescale 1ns/1ps

module supply_reset_model (
	input  wire logic clk,             // system clock, for callers
	output logic      reset_n,         // supply above threshold
	output logic      ext_reset_pin_n, // reset pin level
	output logic      brownout_low     // supply below trigger level
);
	// ------------------------------------------------------------
	// start-up levels
	// ------------------------------------------------------------
	// supply starts below threshold, so the block powers up in reset
	initial begin
		reset_n = 1'b0;
		ext_reset_pin_n = 1'b1;
		brownout_low = 1'b0;
	end

	// supply falls below or reaches the threshold
	task automatic drive_supply(input logic good);
		reset_n <= good;
	endtask

	// pin low, caller holds it past minimum width
	task automatic drive_pin(input logic high);
		ext_reset_pin_n <= high;
	endtask

	// detector crosses the lower or the upper trigger level
	task automatic drive_brownout(input logic low);
		brownout_low <= low;
	endtask
endmodule // supply_reset_model

// ### include/reset_source_controller_map.svh
// Purpose: offsets, field positions, reset values and counts for the
//          reset source controller.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   definitions only.
`ifndef RESET_SOURCE_CONTROLLER_MAP_SVH
`define RESET_SOURCE_CONTROLLER_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define RSC_OFF_CAUSE      12'h000
`define RSC_OFF_IRQ_STAT   12'h004
`define RSC_OFF_IRQ_EN     12'h008
`define RSC_OFF_IRQ_CLR    12'h00C
`define RSC_OFF_CONFIG     12'h010

// ----------------------------------------------------------------------
// cause flag positions
// ----------------------------------------------------------------------
`define RSC_BIT_POR        0
`define RSC_BIT_EXT        1
`define RSC_BIT_BOD        2
`define RSC_BIT_WDT        3

// ----------------------------------------------------------------------
// config field positions and reset values
// ----------------------------------------------------------------------
`define RSC_CFG_WDT_RST    0
`define RSC_CFG_BOD_EN     1
`define RSC_CFG_EXT_DIS    2
`define RSC_CFG_RESET      3'h2

// ----------------------------------------------------------------------
// timing: start-up delay in microseconds per select code
// ----------------------------------------------------------------------
`define RSC_CLK_MHZ        10
`define RSC_TOUT_US_0      1
`define RSC_TOUT_US_1      4100
`define RSC_TOUT_US_2      65000
`define RSC_TOUT_US_3      16

`endif

// ### include/reset_source_controller_pkg.sv
// Purpose: types shared by the reset source controller.
// Assumes: constants live in the map header.
// Notes:   the cause vector is one packed struct.
package reset_source_controller_pkg;

	// ------------------------------------------------------------------
	// reset cause flags, bit 3 down to 0
	// ------------------------------------------------------------------
	typedef struct packed {
		logic watchdog_reset_flag;   // bit 3
		logic brownout_reset_flag;   // bit 2
		logic external_reset_flag;   // bit 1
		logic power_on_reset_flag;   // bit 0
	} reset_cause_t;

	// ------------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_HOLD  = 2'b00,   // a source is active
		ST_DELAY = 2'b01,   // sources gone, counter running
		ST_RUN   = 2'b10    // internal reset released
	} seq_state_t;

endpackage

// ### verilog/reset_source_controller.sv
// Purpose: merges four reset sources into one stretched internal reset
//          and keeps sticky cause flags readable over APB.
// Assumes: clk 10 MHz; reset_n is the power-on detector output, low
//          while the supply sits below threshold.
// Notes:   the pin and the brown-out detector are asynchronous and synchronised here.
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "reset_source_controller_map.svh"

module reset_source_controller #(
	parameter int DELAY_US_0 = `RSC_TOUT_US_0,   // select 0 delay
	parameter int DELAY_US_1 = `RSC_TOUT_US_1,   // select 1 delay
	parameter int DELAY_US_2 = `RSC_TOUT_US_2,   // select 2 delay
	parameter int DELAY_US_3 = `RSC_TOUT_US_3    // select 3 delay
) (
	input  wire logic        clk,                 // system clock
	input  wire logic        reset_n,             // power-on detect, low
	input  wire logic        ext_reset_pin_n,     // external pin, low
	input  wire logic        brownout_low,        // detector below level
	input  wire logic        watchdog_timeout,    // one-cycle timeout
	input  wire logic [1:0]  startup_time_select, // delay select fuse
	input  wire logic        external_reset_disable, // fuse: ignore pin
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             sys_reset_n,         // stretched reset, low
	output logic             ports_reset_n,       // async port reset, low
	output logic             irq                  // cause interrupt
);

	// ------------------------------------------------------------------
	// derived counts: cycles = us * MHz, at least one
	// ------------------------------------------------------------------
	localparam int CNT_0 = (DELAY_US_0 * `RSC_CLK_MHZ < 1) ? 1 :
		DELAY_US_0 * `RSC_CLK_MHZ;
	localparam int CNT_1 = (DELAY_US_1 * `RSC_CLK_MHZ < 1) ? 1 :
		DELAY_US_1 * `RSC_CLK_MHZ;
	localparam int CNT_2 = (DELAY_US_2 * `RSC_CLK_MHZ < 1) ? 1 :
		DELAY_US_2 * `RSC_CLK_MHZ;
	localparam int CNT_3 = (DELAY_US_3 * `RSC_CLK_MHZ < 1) ? 1 :
		DELAY_US_3 * `RSC_CLK_MHZ;
	localparam int CNT_W = 20;                    // counter width

	// refuse delays that the down-counter cannot hold
	if (CNT_0 >= (1 << CNT_W) || CNT_1 >= (1 << CNT_W) ||
	    CNT_2 >= (1 << CNT_W) || CNT_3 >= (1 << CNT_W)) begin : g_cnt_chk
		$error("delay count exceeds counter width");
	end

	// ------------------------------------------------------------------
	// synchronisers for asynchronous inputs
	// ------------------------------------------------------------------
	logic [1:0] ext_sync_q;     // pin level, two stages
	logic [1:0] bod_sync_q;     // brown-out level, two stages
	logic       ext_low;        // synchronised pin low
	logic       bod_low;        // synchronised brown-out

	// two flops each; only stage 1 is read
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ext_sync_q <= 2'h3;
			bod_sync_q <= 2'h0;
		end else begin
			ext_sync_q <= {ext_sync_q[0], ext_reset_pin_n};
			bod_sync_q <= {bod_sync_q[0], brownout_low};
		end
	end
	assign ext_low = !ext_sync_q[1];
	assign bod_low = bod_sync_q[1];

	// ------------------------------------------------------------------
	// configuration register (software owned)
	// ------------------------------------------------------------------
	logic [2:0] cfg_q;          // watchdog reset, bod enable, ext disable
	logic       wdt_mode;       // watchdog in system reset mode
	logic       bod_en;         // brown-out detector enabled
	logic       ext_dis;        // pin ignored by software or fuse
	assign wdt_mode = cfg_q[`RSC_CFG_WDT_RST];
	assign bod_en   = cfg_q[`RSC_CFG_BOD_EN];
	assign ext_dis  = cfg_q[`RSC_CFG_EXT_DIS] | external_reset_disable;

	// ------------------------------------------------------------------
	// source merge
	// ------------------------------------------------------------------
	logic ext_src;   // pin reset qualified
	logic bod_src;   // brown-out qualified
	logic wdt_src;   // watchdog reset qualified
	logic any_src;   // ORed cause, clocked view

	assign ext_src = ext_low & !ext_dis;
	assign bod_src = bod_low & bod_en;
	assign wdt_src = watchdog_timeout & wdt_mode;
	assign any_src = ext_src | bod_src | wdt_src;

	// async port reset: combine raw levels so no clock is needed
	logic port_rst_raw;
	assign port_rst_raw = !reset_n |
		(!ext_reset_pin_n & !ext_dis) | (brownout_low & bod_en);

	// ------------------------------------------------------------------
	// sequencer: hold, delay, run
	// ------------------------------------------------------------------
	reset_source_controller_pkg::seq_state_t state_q;
	logic [CNT_W-1:0] cnt_q;     // delay down-counter
	logic [CNT_W-1:0] load_val;  // selected delay

	always_comb begin
		unique case (startup_time_select)
			2'h0: load_val = CNT_W'(CNT_0);
			2'h1: load_val = CNT_W'(CNT_1);
			2'h2: load_val = CNT_W'(CNT_2);
			2'h3: load_val = CNT_W'(CNT_3);
		endcase
	end

	// state advances; power-on is the master async reset
	// supply low forces hold at once
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= reset_source_controller_pkg::ST_HOLD;
		end else if (any_src) begin
			// watchdog pulse holds one cycle, then counts
			state_q <= reset_source_controller_pkg::ST_HOLD;
		end else begin
			unique case (state_q)
				reset_source_controller_pkg::ST_HOLD: begin
					state_q <= reset_source_controller_pkg::ST_DELAY;
				end
				reset_source_controller_pkg::ST_DELAY: begin
					if (cnt_q == CNT_W'(1)) begin
						state_q <= reset_source_controller_pkg::ST_RUN;
					end
				end
				reset_source_controller_pkg::ST_RUN: begin
					state_q <= reset_source_controller_pkg::ST_RUN;
				end
			endcase
		end
	end

	// counter reloads while held, counts in delay
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= '0;
		end else if (any_src ||
		             state_q == reset_source_controller_pkg::ST_HOLD) begin
			cnt_q <= load_val;
		end else if (state_q == reset_source_controller_pkg::ST_DELAY) begin
			cnt_q <= cnt_q - CNT_W'(1);
		end
	end

	// released output from a flop, leaves reset on a clock edge
	// release on a clock edge
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sys_reset_n <= 1'b0;
		end else begin
			sys_reset_n <= !any_src &&
				state_q == reset_source_controller_pkg::ST_DELAY &&
				cnt_q == CNT_W'(1) ||
				(!any_src &&
				 state_q == reset_source_controller_pkg::ST_RUN);
		end
	end

	// ports: asserted asynchronously by supply, pin and brown-out, released one cycle after the system reset
	always_ff @(posedge clk or posedge port_rst_raw) begin
		if (port_rst_raw) begin
			ports_reset_n <= 1'b0;
		end else begin
			ports_reset_n <= sys_reset_n;
		end
	end

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	logic wr_en;      // write in access phase
	logic rd_en;      // read in access phase
	logic hit;        // mapped address
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & !pwrite;
	assign hit = paddr == `RSC_OFF_CAUSE || paddr == `RSC_OFF_IRQ_STAT ||
		paddr == `RSC_OFF_IRQ_EN || paddr == `RSC_OFF_IRQ_CLR ||
		paddr == `RSC_OFF_CONFIG;

	// ------------------------------------------------------------------
	// cause flags
	// ------------------------------------------------------------------
	reset_source_controller_pkg::reset_cause_t cause_q;
	logic [3:0] cause_set;     // new events this cycle
	logic [3:0] cause_keep;    // software write mask
	logic       por_seen_q;    // first cycle after power-on release
	logic       ext_d1_q;      // previous qualified pin reset
	logic       bod_sync_d1_q; // previous qualified brown-out

	// pin and brown-out flag on their rising edge only
	assign cause_set = {wdt_src, bod_src & !bod_sync_d1_q,
		ext_src & !ext_d1_q, por_seen_q};
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ext_d1_q      <= 1'b0;
			bod_sync_d1_q <= 1'b0;
			por_seen_q    <= 1'b1;
		end else begin
			ext_d1_q      <= ext_src;
			bod_sync_d1_q <= bod_src;
			por_seen_q    <= 1'b0;
		end
	end

	assign cause_keep = (wr_en && paddr == `RSC_OFF_CAUSE) ?
		pwdata[3:0] : 4'hF;

	// power-on clears the others; pin and brown-out keep flags
	// watchdog flag
	// power-on flag, survives all but zero writes
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			// power-on is itself the cause, so only its flag is set
			cause_q <= 4'h1;
		end else begin
			// set wins over a clearing write
			cause_q <= (cause_q & cause_keep) | cause_set;
		end
	end

	// ------------------------------------------------------------------
	// interrupt: sticky status, enable, write-one clear
	// ------------------------------------------------------------------
	logic [3:0] irq_stat_q;   // sticky events
	logic [3:0] irq_en_q;     // enables
	logic [3:0] irq_clr;      // clear mask

	assign irq_clr = (wr_en && paddr == `RSC_OFF_IRQ_CLR) ?
		pwdata[3:0] : 4'h0;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat_q <= 4'h0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | cause_set;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_en_q <= 4'h0;
			cfg_q    <= `RSC_CFG_RESET;
		end else if (wr_en && paddr == `RSC_OFF_IRQ_EN) begin
			irq_en_q <= pwdata[3:0];
		end else if (wr_en && paddr == `RSC_OFF_CONFIG) begin
			cfg_q <= pwdata[2:0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((irq_stat_q & ~irq_clr) | cause_set) & irq_en_q);
		end
	end

	// ------------------------------------------------------------------
	// APB answer, registered
	// ------------------------------------------------------------------
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		unique case (paddr)
			`RSC_OFF_CAUSE:    rd_mux = {28'h0, cause_q};
			`RSC_OFF_IRQ_STAT: rd_mux = {28'h0, irq_stat_q};
			`RSC_OFF_IRQ_EN:   rd_mux = {28'h0, irq_en_q};
			`RSC_OFF_CONFIG:   rd_mux = {29'h0, cfg_q};
			default:           rd_mux = 32'h0;
		endcase
	end

	// pready one cycle in access; data and error registered alongside
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & !penable;
			prdata  <= (psel & !penable & !pwrite) ? rd_mux : 32'h0;
			pslverr <= psel & !penable & !hit;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	a_port_async: assert property (
		@(posedge clk) disable iff (!reset_n)
		port_rst_raw |-> !ports_reset_n)
		else $error("ports not held in reset");
	a_hold_src: assert property (
		@(posedge clk) disable iff (!reset_n)
		any_src |=> !sys_reset_n)
		else $error("source did not hold reset");
	a_no_early: assert property (
		@(posedge clk) disable iff (!reset_n)
		$rose(sys_reset_n) |->
		$past(state_q) == reset_source_controller_pkg::ST_DELAY)
		else $error("release without delay");
	// a low pin while disabled must leave a running system running
	a_ext_mask: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ext_dis && ext_low && !bod_src && !wdt_src &&
		 state_q == reset_source_controller_pkg::ST_RUN) |=> sys_reset_n)
		else $error("pin used while disabled");
	a_wdt_mode: assert property (
		@(posedge clk) disable iff (!reset_n)
		(watchdog_timeout && !wdt_mode && !ext_src && !bod_src &&
		 state_q == reset_source_controller_pkg::ST_RUN) |=> sys_reset_n)
		else $error("watchdog reset outside mode");
	a_wdt_flag: assert property (
		@(posedge clk) disable iff (!reset_n)
		wdt_src |=> cause_q.watchdog_reset_flag)
		else $error("watchdog flag not set");
	a_ext_flag: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ext_src && !ext_d1_q) |=> cause_q.external_reset_flag)
		else $error("external flag not set");
	a_one_keeps: assert property (
		@(posedge clk) disable iff (!reset_n)
		(wr_en && paddr == `RSC_OFF_CAUSE && pwdata[0] &&
		 cause_q.power_on_reset_flag) |=> cause_q.power_on_reset_flag)
		else $error("write one cleared flag");
	// only a zero write may drop the power-on flag
	a_por_flag: assert property (
		@(posedge clk) disable iff (!reset_n)
		(cause_q.power_on_reset_flag &&
		 !(wr_en && paddr == `RSC_OFF_CAUSE && !pwdata[0])) |=>
		cause_q.power_on_reset_flag)
		else $error("power-on flag lost");
	a_irq_level: assert property (
		@(posedge clk) disable iff (!reset_n)
		(|(irq_stat_q & irq_en_q) && irq_clr == 4'h0) |=> irq)
		else $error("irq not raised");
	c_ext_reset: cover property (@(posedge clk) disable iff (!reset_n)
		ext_src ##1 !ext_src ##[1:300] $rose(sys_reset_n));
	c_wdt_reset: cover property (@(posedge clk) disable iff (!reset_n)
		wdt_src ##1 !sys_reset_n);
	c_bod_reset: cover property (@(posedge clk) disable iff (!reset_n)
		$rose(bod_src));

endmodule // reset_source_controller
